// File: design/usb_ep_ctrl.sv
//
// Overview of operation
// - Shared IN/OUT status registers follow the endpoint index, 1 to 4.
// - CPU sets IN ready after loading; ready plus occupied give status.
// - Isochronous IN token with no packet sets underrun and error flag.
// - IN halt bit set makes every IN transaction return STALL.
// - IN isochronous bit makes the endpoint isochronous for IN.
// - IN occupied bit reads one whenever the IN FIFO holds data.
// - IN flush empties one packet or drops older of two.
// - Auto-ready sets IN ready once max packet bytes are written.
// - Endpoint 0 OUT status register is fully reserved, reads zero.
// - OUT ready sets on good packet; cleared by CPU or unload.
// - Isochronous OUT token with ready still set flags overrun.
// - OUT halt bit set makes OUT transactions return STALL.
// - OUT isochronous bit makes the endpoint isochronous for OUT.
// - Oversized OUT packet sets forced halt, STALL until CPU clears.
// - CRC or stuffing error on isochronous packet sets data error.
// - OUT flush empties one packet or drops older of two.
// - Auto-release clears OUT ready after max packet bytes are read.
// - IN max packet resets to 8 on endpoint 0, else 0.
// - OUT max packet resets to 0; endpoint 0 uses IN value.
// - Good OUT packet loads byte count; read low before high.
// - FIFO data ports push IN bytes and pop OUT bytes.
// - Endpoint 0 last-data mark stalls further data until status ends.
//
`timescale 1ns/100ps
module usb_ep_ctrl #(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire usb_ep_pkg::token_s TOKEN,
  input  wire usb_ep_pkg::rx_s   RX,
  input  wire logic              TX_POP,
  input  wire logic              TX_DONE,
  input  wire logic              STATUS_DONE,
  output logic      [7:0]        TX_BYTE,
  output usb_ep_pkg::hs_s        HANDSHAKE,
  output logic                   EP_ERR_SET
);

  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int NE = usb_ep_pkg::NUM_EP;
  localparam int CW = usb_ep_pkg::CNT_W;

  logic [31:0]    prdata_q;
  logic           pready_q;
  logic           slverr_q;
  logic [2:0]     idx_q;
  logic           last_q;
  logic [2:0]     cur_q;
  logic           act_q;
  logic           stat_q;
  logic [CW-1:0]  len_q;
  logic [1:0]     hi_q;
  logic [7:0]     txb_q;
  usb_ep_pkg::hs_s hs_q;
  logic           err_q;

  logic [7:0]     in_q      [NE];
  logic [7:0]     out_q     [NE];
  logic [7:0]     in_mps_q  [NE];
  logic [7:0]     out_mps_q [NE];
  logic [CW-1:0]  cnt_q     [NE];
  logic [7:0]     tx_head   [NE];
  logic [7:0]     rx_head   [NE];
  logic [AW:0]    tx_count  [NE];
  logic [1:0]     tx_pkts   [NE];
  logic [1:0]     rx_pkts   [NE];
  logic [NE-1:0]  err_vec;

  assign PRDATA     = prdata_q;
  assign PREADY     = pready_q;
  assign PSLVERR    = slverr_q;
  assign TX_BYTE    = txb_q;
  assign HANDSHAKE  = hs_q;
  assign EP_ERR_SET = err_q;

  // Bus phases and address decode
  wire        setup    = PSEL && !PENABLE;
  wire        fire     = PSEL && PENABLE && pready_q;
  wire        wr_fire  = fire && PWRITE;
  wire        rd_fire  = fire && !PWRITE;
  wire [7:0]  wd       = PWDATA[7:0];
  wire        hit_idx  = PADDR == usb_ep_pkg::OFS_INDEX;
  wire        hit_in   = PADDR == usb_ep_pkg::OFS_IN_CSR;
  wire        hit_out  = PADDR == usb_ep_pkg::OFS_OUT_CSR;
  wire        hit_inm  = PADDR == usb_ep_pkg::OFS_IN_MPS;
  wire        hit_outm = PADDR == usb_ep_pkg::OFS_OUT_MPS;
  wire        hit_lo   = PADDR == usb_ep_pkg::OFS_CNT_LO;
  wire        hit_hi   = PADDR == usb_ep_pkg::OFS_CNT_HI;
  wire        hit_ep0  = PADDR == usb_ep_pkg::OFS_EP0_CTRL;
  wire        hit_fifo = PADDR >= usb_ep_pkg::OFS_FIFO0
                      && PADDR <= usb_ep_pkg::OFS_FIFO_LAST
                      && PADDR[1:0] == 2'b00;
  wire [7:0]  fifo_ofs = PADDR - usb_ep_pkg::OFS_FIFO0;
  wire [2:0]  fifo_ep  = fifo_ofs[4:2];
  wire        mapped   = hit_idx || hit_in || hit_out || hit_inm
                      || hit_outm || hit_lo || hit_hi || hit_ep0
                      || hit_fifo;

  wire [2:0]  idx      = (idx_q < 3'(NE)) ? idx_q : 3'd0;
  wire        idx_x    = idx != 3'd0;
  wire [7:0]  in_csr   = in_q[idx];
  wire        occ_sel  = tx_count[idx] != '0;
  wire [CW-1:0] cnt_sel = cnt_q[idx];

  // Read data selection
  // ready with occupied
  wire [7:0]  rd_in    = idx_x ? {in_csr[7], 1'b0, occ_sel, in_csr[4:0]}
                               : 8'h00;
  wire [7:0]  rd_out   = idx_x ? {out_q[idx][7], 1'b0, out_q[idx][5:0]}
                               : 8'h00;
  wire [7:0]  rd_outm  = idx_x ? out_mps_q[idx] : 8'h00;
  wire [7:0]  rdata    = hit_idx  ? {5'h00, idx_q}
                       : hit_in   ? rd_in
                       : hit_out  ? rd_out
                       : hit_inm  ? in_mps_q[idx]
                       : hit_outm ? rd_outm
                       : hit_lo   ? cnt_sel[7:0]
                       : hit_hi   ? {6'h00, hi_q}
                       : hit_ep0  ? {7'h00, last_q}
                       : hit_fifo ? rx_head[fifo_ep]
                       : 8'h00;

  // Token side: endpoint under transfer and its settings
  wire        tok_ok   = TOKEN.ep < 3'(NE);
  wire [2:0]  tok_ep   = tok_ok ? TOKEN.ep : 3'd0;
  wire [7:0]  tok_in   = in_q[tok_ep];
  wire        rx_end   = RX.end_ok || RX.end_crc || RX.end_stuff;
  wire [7:0]  cur_mps  = (cur_q == 3'd0) ? in_mps_q[0] : out_mps_q[cur_q];
  wire [CW-1:0] mps_x  = CW'(cur_mps);
  wire [7:0]  cur_out  = out_q[cur_q];
  wire        too_long = len_q > mps_x;
  wire        rx_push  = RX.valid && act_q && (len_q < mps_x);
  wire        in_last  = tok_ep == 3'd0 && last_q && !TOKEN.status_stage;
  wire        out_last = cur_q == 3'd0 && last_q && !stat_q;

  // OUT verdict at the end of the data packet
  // halt answers STALL
  wire        out_stall = cur_out[usb_ep_pkg::RX_HALT]
                       || cur_out[usb_ep_pkg::RX_FORCE] || out_last;
  wire        accept   = act_q && RX.end_ok && !out_stall && !too_long
                      && rx_pkts[cur_q] != 2'd2;
  wire        rx_abort = act_q && rx_end && !accept;

  // IN answer at the token
  // IN halt stalls
  wire        in_stall = tok_in[usb_ep_pkg::TX_HALT] || in_last;
  wire usb_ep_pkg::handshake_e hs_in =
      in_stall                      ? usb_ep_pkg::HS_STALL
    : tok_in[usb_ep_pkg::TX_RDY]    ? usb_ep_pkg::HS_DATA
    : tok_in[usb_ep_pkg::TX_ISO]    ? usb_ep_pkg::HS_NONE
    :                                 usb_ep_pkg::HS_NAK;
  wire usb_ep_pkg::handshake_e hs_out =
      (out_stall || too_long)       ? usb_ep_pkg::HS_STALL
    : cur_out[usb_ep_pkg::RX_ISO]   ? usb_ep_pkg::HS_NONE
    : accept                        ? usb_ep_pkg::HS_ACK
    :                                 usb_ep_pkg::HS_NAK;
  wire        hs_fire  = (TOKEN.in_start && tok_ok)
                      || (act_q && RX.end_ok);

  // Bus slave: zero wait answer, data and error caught in setup
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pready_q <= 1'b0;
      slverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      slverr_q <= setup && !mapped;
      if (setup) begin
        prdata_q <= {24'h00_0000, rdata};
      end
    end
  end

  // Index, endpoint 0 last-data mark and count high snapshot
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      idx_q  <= 3'd0;
      last_q <= 1'b0;
      hi_q   <= 2'b00;
    end else begin
      if (wr_fire && hit_idx) begin
        idx_q <= wd[2:0];
      end
      if (wr_fire && hit_ep0 && wd[usb_ep_pkg::EP0_LAST]) begin
        last_q <= 1'b1;
      end else if (STATUS_DONE) begin
        last_q <= 1'b0;
      end
      if (rd_fire && hit_lo) begin
        hi_q <= cnt_sel[CW-1:8];
      end
    end
  end

  // Transfer tracking, handshake and transmit byte
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cur_q  <= 3'd0;
      act_q  <= 1'b0;
      stat_q <= 1'b0;
      len_q  <= '0;
      txb_q  <= 8'h00;
      hs_q   <= '{valid: 1'b0, code: usb_ep_pkg::HS_NONE};
      err_q  <= 1'b0;
    end else begin
      if ((TOKEN.in_start || TOKEN.out_start) && tok_ok) begin
        cur_q  <= TOKEN.ep;
        stat_q <= TOKEN.status_stage;
      end
      if (TOKEN.out_start && tok_ok) begin
        act_q <= 1'b1;
        len_q <= '0;
      end else if (rx_end) begin
        act_q <= 1'b0;
      end else if (RX.valid && act_q) begin
        len_q <= len_q + 1'b1;
      end
      if (TX_POP) begin
        txb_q <= tx_head[cur_q];
      end
      hs_q.valid <= hs_fire;
      hs_q.code  <= TOKEN.in_start ? hs_in : hs_out;
      err_q      <= |err_vec;
    end
  end

  // Per-endpoint registers and FIFOs
  for (genvar e = 0; e < NE; e++) begin : g_ep
    logic [AW:0]   tx_pend;
    logic [AW:0]   rx_len;
    logic [AW:0]   rx_rd_q;
    logic [1:0]    txp;
    logic [1:0]    rxp;
    wire           csr_ok  = e != 0;
    wire           sel     = idx == 3'(e);
    wire           mine    = cur_q == 3'(e);
    wire           tokin   = TOKEN.in_start && TOKEN.ep == 3'(e);
    wire           tokout  = TOKEN.out_start && TOKEN.ep == 3'(e);
    wire           w_in    = wr_fire && hit_in && sel && csr_ok;
    wire           w_out   = wr_fire && hit_out && sel && csr_ok;
    wire           fifo_w  = wr_fire && hit_fifo && fifo_ep == 3'(e);
    wire           fifo_r  = rd_fire && hit_fifo && fifo_ep == 3'(e);
    wire [7:0]     iq      = in_q[e];
    wire [7:0]     oq      = out_q[e];
    wire [CW-1:0]  omaxp   = CW'((e == 0) ? in_mps_q[e] : out_mps_q[e]);

    wire auto_hit = iq[usb_ep_pkg::TX_AUTO] && fifo_w
                 && CW'(tx_pend) + 1'b1 == CW'(in_mps_q[e]);
    wire tx_set   = (w_in && wd[usb_ep_pkg::TX_RDY]) || auto_hit;
    wire tx_rel   = TX_DONE && mine;
    wire tx_flush = w_in && wd[usb_ep_pkg::TX_FLUSH];
    wire under    = tokin && csr_ok && iq[usb_ep_pkg::TX_ISO]
                 && !iq[usb_ep_pkg::TX_RDY];
    wire over     = tokout && csr_ok && oq[usb_ep_pkg::RX_ISO]
                 && oq[usb_ep_pkg::RX_RDY];
    wire unload   = fifo_r && ((CW'(rx_rd_q) + 1'b1 == CW'(rx_len))
                 || (oq[usb_ep_pkg::RX_AUTO]
                     && CW'(rx_rd_q) + 1'b1 == omaxp));
    wire rx_clr   = w_out && !wd[usb_ep_pkg::RX_RDY]
                 && oq[usb_ep_pkg::RX_RDY];
    wire rx_drop  = (w_out && wd[usb_ep_pkg::RX_FLUSH]) || rx_clr;
    wire force_s  = mine && act_q && RX.end_ok && too_long && csr_ok;
    wire derr_s   = mine && act_q && (RX.end_crc || RX.end_stuff)
                 && oq[usb_ep_pkg::RX_ISO] && csr_ok;

    assign err_vec[e]  = under || over;
    assign tx_pkts[e]  = txp;
    assign rx_pkts[e]  = rxp;

    usb_ep_fifo #(.DEPTH(FIFO_DEPTH)) u_tx (
      .clk        (SYS_CLK),
      .rst_n      (RST_N),
      .push       (fifo_w),
      .push_data  (wd),
      .pop        (TX_POP && mine),
      .commit     (tx_set),
      .release_pkt(tx_rel),
      .drop_head  (tx_flush),
      .abort      (1'b0),
      .head_data  (tx_head[e]),
      .count      (tx_count[e]),
      .pend       (tx_pend),
      .head_len   (),
      .pkts       (txp)
    );

    usb_ep_fifo #(.DEPTH(FIFO_DEPTH)) u_rx (
      .clk        (SYS_CLK),
      .rst_n      (RST_N),
      .push       (rx_push && mine),
      .push_data  (RX.data),
      .pop        (fifo_r),
      .commit     (accept && mine),
      .release_pkt(unload),
      .drop_head  (rx_drop),
      .abort      (rx_abort && mine),
      .head_data  (rx_head[e]),
      .count      (),
      .pend       (),
      .head_len   (rx_len),
      .pkts       (rxp)
    );

    // Status and control bits; hardware set wins over CPU clear
    always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
        in_q[e]    <= usb_ep_pkg::CSR_RST;
        out_q[e]   <= usb_ep_pkg::CSR_RST;
        in_mps_q[e]  <= (e == 0) ? usb_ep_pkg::EP0_MPS_RST
                                 : usb_ep_pkg::EPX_MPS_RST;
        out_mps_q[e] <= usb_ep_pkg::EPX_MPS_RST;
        cnt_q[e]   <= '0;
        rx_rd_q    <= '0;
      end else begin
        if (wr_fire && hit_inm && sel) begin
          in_mps_q[e] <= wd;
        end
        if (wr_fire && hit_outm && sel && csr_ok) begin
          out_mps_q[e] <= wd;
        end
        if (w_in) begin
          in_q[e][usb_ep_pkg::TX_HALT]  <= wd[usb_ep_pkg::TX_HALT];
          in_q[e][usb_ep_pkg::TX_ISO]   <= wd[usb_ep_pkg::TX_ISO];
          in_q[e][usb_ep_pkg::TX_STCHG] <= wd[usb_ep_pkg::TX_STCHG];
          in_q[e][usb_ep_pkg::TX_AUTO]  <= wd[usb_ep_pkg::TX_AUTO];
        end
        in_q[e][usb_ep_pkg::TX_RDY] <= tx_set
          || (iq[usb_ep_pkg::TX_RDY] && !(tx_rel && txp == 2'd1)
              && !(tx_flush && txp != 2'd2));
        in_q[e][usb_ep_pkg::TX_UNDER] <= under
          || (iq[usb_ep_pkg::TX_UNDER]
              && !(w_in && !wd[usb_ep_pkg::TX_UNDER]));
        if (w_out) begin
          out_q[e][usb_ep_pkg::RX_HALT] <= wd[usb_ep_pkg::RX_HALT];
          out_q[e][usb_ep_pkg::RX_ISO]  <= wd[usb_ep_pkg::RX_ISO];
          out_q[e][usb_ep_pkg::RX_AUTO] <= wd[usb_ep_pkg::RX_AUTO];
        end
        out_q[e][usb_ep_pkg::RX_RDY] <= (accept && mine)
          || (oq[usb_ep_pkg::RX_RDY] && !rx_clr
              && !(unload && rxp == 2'd1)
              && !(rx_drop && rxp != 2'd2));
        out_q[e][usb_ep_pkg::RX_OVER] <= over
          || (oq[usb_ep_pkg::RX_OVER]
              && !(w_out && !wd[usb_ep_pkg::RX_OVER]));
        out_q[e][usb_ep_pkg::RX_FORCE] <= force_s
          || (oq[usb_ep_pkg::RX_FORCE]
              && !(w_out && !wd[usb_ep_pkg::RX_FORCE]));
        out_q[e][usb_ep_pkg::RX_DERR] <= derr_s
          || (oq[usb_ep_pkg::RX_DERR]
              && !(w_out && !wd[usb_ep_pkg::RX_DERR]));
        if (accept && mine) begin
          cnt_q[e] <= len_q;
        end
        if (unload || rx_drop) begin
          rx_rd_q <= '0;
        end else if (fifo_r) begin
          rx_rd_q <= rx_rd_q + 1'b1;
        end
      end
    end
  end

endmodule

// File: pkg/usb_ep_pkg.sv
package usb_ep_pkg;

  // Endpoint count and received byte count width
  localparam int NUM_EP = 5;
  localparam int CNT_W  = 10;

  // Register byte offsets
  localparam logic [7:0] OFS_INDEX     = 8'h00;
  localparam logic [7:0] OFS_IN_CSR    = 8'h04;
  localparam logic [7:0] OFS_OUT_CSR   = 8'h08;
  localparam logic [7:0] OFS_IN_MPS    = 8'h0C;
  localparam logic [7:0] OFS_OUT_MPS   = 8'h10;
  localparam logic [7:0] OFS_CNT_LO    = 8'h14;
  localparam logic [7:0] OFS_CNT_HI    = 8'h18;
  localparam logic [7:0] OFS_EP0_CTRL  = 8'h1C;
  localparam logic [7:0] OFS_FIFO0     = 8'h20;
  localparam logic [7:0] OFS_FIFO_LAST = 8'h30;

  // IN control/status bit positions
  localparam int TX_RDY   = 0;
  localparam int TX_UNDER = 1;
  localparam int TX_HALT  = 2;
  localparam int TX_ISO   = 3;
  localparam int TX_STCHG = 4;
  localparam int TX_OCC   = 5;
  localparam int TX_FLUSH = 6;
  localparam int TX_AUTO  = 7;

  // OUT control/status bit positions
  localparam int RX_RDY   = 0;
  localparam int RX_OVER  = 1;
  localparam int RX_HALT  = 2;
  localparam int RX_ISO   = 3;
  localparam int RX_FORCE = 4;
  localparam int RX_DERR  = 5;
  localparam int RX_FLUSH = 6;
  localparam int RX_AUTO  = 7;

  // Endpoint 0 control bit position
  localparam int EP0_LAST = 0;

  // Reset values
  localparam logic [7:0] CSR_RST      = 8'h00;
  localparam logic [7:0] EP0_MPS_RST  = 8'h08;
  localparam logic [7:0] EPX_MPS_RST  = 8'h00;

  typedef enum logic [2:0] {
    HS_NONE, HS_ACK, HS_NAK, HS_STALL, HS_DATA
  } handshake_e;

  typedef struct packed {
    logic       in_start;
    logic       out_start;
    logic       status_stage;
    logic [2:0] ep;
  } token_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       end_ok;
    logic       end_crc;
    logic       end_stuff;
  } rx_s;

  typedef struct packed {
    logic       valid;
    handshake_e code;
  } hs_s;

endpackage

// File: design/usb_ep_fifo.sv
`timescale 1ns/100ps
module usb_ep_fifo #(
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          push,
  input  wire logic [7:0]    push_data,
  input  wire logic          pop,
  input  wire logic          commit,
  input  wire logic          release_pkt,
  input  wire logic          drop_head,
  input  wire logic          abort,
  output logic      [7:0]    head_data,
  output logic      [AW:0]   count,
  output logic      [AW:0]   pend,
  output logic      [AW:0]   head_len,
  output logic      [1:0]    pkts
);

  logic [7:0]    mem [0:DEPTH-1];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   pend_q;
  logic [AW:0]   len0_q;
  logic [AW:0]   len1_q;
  logic [1:0]    pkts_q;

  // Occupancy guards and length of the packet being closed
  wire         full      = cnt_q == (AW+1)'(DEPTH);
  wire         push_ok   = push && !full;
  wire         pop_ok    = pop && (cnt_q != '0);
  wire         commit_ok = commit && (pkts_q != 2'd2);
  wire [AW:0]  push_ext  = {{AW{1'b0}}, push_ok};
  wire [AW:0]  pop_ext   = {{AW{1'b0}}, pop_ok};
  wire [AW:0]  new_len   = pend_q + push_ext;

  assign head_data = mem[rd_q];
  assign count     = cnt_q;
  assign pend      = pend_q;
  assign head_len  = len0_q;
  assign pkts      = pkts_q;

  // Byte storage
  always_ff @(posedge clk) begin
    if (push_ok) begin
      mem[wr_q] <= push_data;
    end
  end

  // Pointers and packet bookkeeping, at most two packets held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q   <= '0;
      rd_q   <= '0;
      cnt_q  <= '0;
      pend_q <= '0;
      len0_q <= '0;
      len1_q <= '0;
      pkts_q <= 2'd0;
    end else if (drop_head && pkts_q == 2'd2) begin
      rd_q   <= rd_q + len0_q[AW-1:0];  // Drop only the older packet
      cnt_q  <= cnt_q - len0_q;
      len0_q <= len1_q;
      pkts_q <= 2'd1;
    end else if (drop_head) begin
      wr_q   <= '0;
      rd_q   <= '0;
      cnt_q  <= '0;
      pend_q <= '0;
      len0_q <= '0;
      pkts_q <= 2'd0;
    end else if (abort) begin
      wr_q   <= wr_q - pend_q[AW-1:0];  // Rewind a rejected packet
      cnt_q  <= cnt_q - pend_q;
      pend_q <= '0;
    end else begin
      if (push_ok) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop_ok) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q  <= cnt_q + push_ext - pop_ext;
      pend_q <= commit_ok ? '0 : new_len;
      if (release_pkt && pkts_q != 2'd0) begin
        len0_q <= (commit_ok && pkts_q == 2'd1) ? new_len : len1_q;
        pkts_q <= pkts_q - 2'd1 + {1'b0, commit_ok};
      end else if (commit_ok) begin
        if (pkts_q == 2'd0) begin
          len0_q <= new_len;
        end else begin
          len1_q <= new_len;
        end
        pkts_q <= pkts_q + 2'd1;
      end
    end
  end

endmodule

// File: testbench/usb_ep_ctrl_props.sv
`timescale 1ns/100ps
module usb_ep_ctrl_props (
  input wire logic               SYS_CLK,
  input wire logic               RST_N,
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic [7:0]         PADDR,
  input wire logic [31:0]        PRDATA,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  input wire usb_ep_pkg::token_s TOKEN,
  input wire usb_ep_pkg::rx_s    RX,
  input wire usb_ep_pkg::hs_s    HANDSHAKE,
  input wire logic               EP_ERR_SET
);
  wire tok_any;

  // Any token start
  assign tok_any = TOKEN.in_start || TOKEN.out_start;

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // Bus answers with zero wait states, one cycle long
  a_zero_wait: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  a_err_unmapped: assert property (PSEL && !PENABLE && PADDR > 8'h30
    |=> PSLVERR) else $error("unmapped not refused");
  a_err_mapped: assert property (PSEL && !PENABLE && PADDR <= 8'h30
    && PADDR[1:0] == 2'b00 |=> !PSLVERR) else $error("mapped refused");
  a_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  a_in_answer: assert property (
    TOKEN.in_start && TOKEN.ep < 3'd5 |=> HANDSHAKE.valid)
    else $error("no answer to in token");
  a_hs_pulse: assert property (HANDSHAKE.valid |=> !HANDSHAKE.valid)
    else $error("handshake held");
  a_bad_quiet: assert property (
    RX.end_crc || RX.end_stuff |=> !HANDSHAKE.valid)
    else $error("handshake on bad packet");
  a_err_cause: assert property (
    EP_ERR_SET |-> $past(tok_any) || $past(tok_any, 2))
    else $error("error pulse without token");
endmodule

// File: testbench/host_model.sv
`timescale 1ns/100ps
module host_model (
  input  wire logic          clk,
  output usb_ep_pkg::token_s tok,
  output usb_ep_pkg::rx_s    rx,
  output logic               pop,
  output logic               done
);
  // Bus idle at start
  initial begin
    tok = '0;
    rx = '0;
    pop = 1'b0;
    done = 1'b0;
  end

  // Token start pulse of one cycle
  task automatic token(input logic in, input logic [2:0] ep);
    @(posedge clk);
    tok <= '{in, !in, 1'b0, ep};
    @(posedge clk);
    tok <= '0;
  endtask

  // OUT packet, may exceed size; kind 0 good, 1 CRC, 2 stuffing
  task automatic packet(input logic [2:0] ep, input int n, input int k);
    token(1'b0, ep);
    for (int i = 0; i < n; i++) begin
      rx <= '{1'b1, 8'hA0 + 8'(i), 1'b0, 1'b0, 1'b0};
      @(posedge clk);
    end
    // Released data line shows a changing pattern
    rx <= '{1'b0, 8'h5F, k == 0, k == 1, k == 2};
    @(posedge clk);
    rx <= '{1'b0, 8'hA0, 1'b0, 1'b0, 1'b0};
  endtask

  // One byte taken, or packet delivered
  task automatic take(input logic fin);
    @(posedge clk);
    {pop, done} <= {!fin, fin};
    @(posedge clk);
    {pop, done} <= 2'b00;
  endtask
endmodule

// File: testbench/test_usb_ep_ctrl.sv
`timescale 1ns/100ps
module test_usb_ep_ctrl;
  localparam logic [7:0] idx     = usb_ep_pkg::OFS_INDEX;
  localparam logic [7:0] in_csr  = usb_ep_pkg::OFS_IN_CSR;
  localparam logic [7:0] out_csr = usb_ep_pkg::OFS_OUT_CSR;
  localparam logic [7:0] fifo1   = 8'h24;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0;
  logic        pw = 1'b0, pready, perr, perr_q, txp, txd, eset, sd = 1'b0;
  logic [7:0]  pa = 8'h00, tx_byte;
  logic [31:0] pd = 32'h0, prd, q;
  usb_ep_pkg::token_s     tok;
  usb_ep_pkg::rx_s        rx;
  usb_ep_pkg::hs_s        hs;
  usb_ep_pkg::handshake_e hs_q = usb_ep_pkg::HS_NONE;
  int errors = 0, checks_done = 0, cyc = 0, eset_n = 0;

  usb_ep_ctrl usb_ep_ctrl_i (
    .SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pw), .PADDR(pa), .PWDATA(pd), .PRDATA(prd),
    .PREADY(pready), .PSLVERR(perr), .TOKEN(tok), .RX(rx),
    .TX_POP(txp), .TX_DONE(txd), .STATUS_DONE(sd),
    .TX_BYTE(tx_byte), .HANDSHAKE(hs), .EP_ERR_SET(eset));
  host_model host_model_i (
    .clk(clk), .tok(tok), .rx(rx), .pop(txp), .done(txd));

  // Clock
  always #4 clk = ~clk;

  // Cycle limit, handshake and error pulse capture
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (hs.valid) hs_q <= hs.code;
    if (eset) eset_n <= eset_n + 1;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // One bus transfer; result in q and perr_q
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pw, pa, pd} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prd;
    perr_q = perr;
    {psel, pen} <= 2'b00;
  endtask

  task automatic hs_chk(input usb_ep_pkg::handshake_e e);
    repeat (3) @(posedge clk);
    chk("handshake", e, hs_q);
    hs_q = usb_ep_pkg::HS_NONE;
  endtask

  task automatic t_reset();
    apb(0, usb_ep_pkg::OFS_IN_MPS, 0);
    chk("in mps ep0", 8, q);
    apb(0, out_csr, 0);
    chk("out csr ep0", 0, q);
    apb(1, idx, 1);
    apb(0, usb_ep_pkg::OFS_IN_MPS, 0);
    chk("in mps ep1", 0, q);
    apb(0, usb_ep_pkg::OFS_OUT_MPS, 0);
    chk("out mps ep1", 0, q);
    apb(0, 8'h34, 0);
    chk("unmapped", 1, perr_q);
    $display("reset test done");
  endtask

  task automatic t_out();
    apb(1, usb_ep_pkg::OFS_OUT_MPS, 4);
    host_model_i.packet(3'd1, 3, 0);
    hs_chk(usb_ep_pkg::HS_ACK);
    apb(0, out_csr, 0);
    chk("out ready", 1, q);
    apb(0, usb_ep_pkg::OFS_CNT_LO, 0);
    chk("count low", 3, q);
    apb(0, usb_ep_pkg::OFS_CNT_HI, 0);
    chk("count high", 0, q);
    for (int i = 0; i < 3; i++) begin
      apb(0, fifo1, 0);
      chk("out byte", 8'hA0 + i, q);
    end
    apb(0, out_csr, 0);
    chk("out unloaded", 0, q);
    $display("out test done");
  endtask

  task automatic t_in();
    apb(1, fifo1, 8'h5A);
    apb(1, fifo1, 8'h5B);
    apb(0, in_csr, 0);
    chk("in occupied", 8'h20, q);
    host_model_i.token(1, 3'd1);
    hs_chk(usb_ep_pkg::HS_NAK);
    apb(1, in_csr, 1);
    host_model_i.token(1, 3'd1);
    hs_chk(usb_ep_pkg::HS_DATA);
    host_model_i.take(0);
    @(posedge clk);
    chk("tx byte", 8'h5A, tx_byte);
    host_model_i.take(0);
    host_model_i.take(1);
    apb(0, in_csr, 0);
    chk("in empty", 0, q);
    $display("in test done");
  endtask

  task automatic t_halt();
    apb(1, in_csr, 4);
    host_model_i.token(1, 3'd1);
    hs_chk(usb_ep_pkg::HS_STALL);
    apb(1, idx, 2);
    apb(0, in_csr, 0);
    chk("ep2 in csr", 0, q);
    host_model_i.token(1, 3'd2);
    hs_chk(usb_ep_pkg::HS_NAK);
    apb(1, idx, 1);
    apb(1, in_csr, 0); // no rate feedback bit
    apb(1, out_csr, 4);
    host_model_i.packet(3'd1, 1, 0);
    hs_chk(usb_ep_pkg::HS_STALL);
    apb(1, out_csr, 0);
    $display("halt test done");
  endtask

  task automatic t_iso();
    apb(1, in_csr, 8);
    host_model_i.token(1, 3'd1);
    apb(0, in_csr, 0);
    chk("underrun", 8'h0A, q);
    apb(1, in_csr, 8);
    apb(0, in_csr, 0);
    chk("underrun clear", 8'h08, q);
    apb(1, out_csr, 8);
    host_model_i.packet(3'd1, 2, 1);
    apb(0, out_csr, 0);
    chk("data error", 8'h28, q);
    host_model_i.packet(3'd1, 2, 0);
    host_model_i.packet(3'd1, 1, 0);
    apb(0, out_csr, 0);
    chk("overrun", 8'h2B, q);
    chk("error pulses", 2, eset_n);
    apb(1, out_csr, 8'h49);
    apb(0, out_csr, 0);
    chk("older dropped", 8'h09, q);
    apb(0, fifo1, 0);
    apb(0, out_csr, 0);
    chk("newer unloaded", 8'h08, q);
    $display("iso test done");
  endtask

  task automatic t_misc();
    apb(1, idx, 2);
    apb(1, usb_ep_pkg::OFS_OUT_MPS, 2);
    host_model_i.packet(3'd2, 3, 0);
    hs_chk(usb_ep_pkg::HS_STALL);
    apb(0, out_csr, 0);
    chk("forced halt", 8'h10, q);
    apb(1, idx, 3);
    apb(1, usb_ep_pkg::OFS_IN_MPS, 2);
    apb(1, in_csr, 8'h80);
    apb(1, 8'h2C, 1);
    apb(1, 8'h2C, 2);
    apb(0, in_csr, 0);
    chk("auto ready", 8'hA1, q);
    apb(1, in_csr, 8'hC0);
    apb(0, in_csr, 0);
    chk("flushed", 8'h80, q);
    apb(1, usb_ep_pkg::OFS_EP0_CTRL, 1);
    host_model_i.token(1, 3'd0);
    hs_chk(usb_ep_pkg::HS_STALL);
    sd <= 1'b1;
    @(posedge clk) sd <= 1'b0;
    apb(0, usb_ep_pkg::OFS_EP0_CTRL, 0);
    chk("last mark", 0, q);
    $display("misc test done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Reset, then the scenarios
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_out();
    t_in();
    t_halt();
    t_iso();
    t_misc();
    tally_and_finish();
  end
endmodule

bind usb_ep_ctrl usb_ep_ctrl_props usb_ep_ctrl_props_i (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TOKEN(TOKEN), .RX(RX), .HANDSHAKE(HANDSHAKE), .EP_ERR_SET(EP_ERR_SET));
